// file: fsp_cfg.svh
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// Command codes
`define FSP_OP_READ_LOW      8'h05
`define FSP_OP_READ_MID      8'h35
`define FSP_OP_READ_HIGH     8'h15
`define FSP_OP_WRITE_LOW     8'h01
`define FSP_OP_WRITE_MID     8'h31
`define FSP_OP_WRITE_HIGH    8'h11
`define FSP_OP_WRITE_ENABLE  8'h06
`define FSP_OP_WRITE_DISABLE 8'h04
`define FSP_OP_PAGE_WRITE    8'h02
`define FSP_OP_SECTOR_CLEAR  8'h20
`define FSP_OP_BLOCK32_CLEAR 8'h52
`define FSP_OP_BLOCK64_CLEAR 8'hD8
`define FSP_OP_CHIP_CLEAR_A  8'hC7
`define FSP_OP_CHIP_CLEAR_B  8'h60
`define FSP_OP_PAUSE         8'h75
`define FSP_OP_RESUME        8'h7A
`define FSP_OP_RESET_ARM     8'h66
`define FSP_OP_RESET_GO      8'h99

// Status word field positions
`define FSP_BIT_BUSY      0
`define FSP_BIT_PERMIT    1
`define FSP_BIT_GUARD_LO  2
`define FSP_BIT_GUARD_HI  6
`define FSP_BIT_LOCK_LOW  7
`define FSP_BIT_LOCK_HIGH 8
`define FSP_BIT_QUAD      9
`define FSP_BIT_PGM_PAUSE 10
`define FSP_BIT_SEC_LO    11
`define FSP_BIT_SEC_HI    13
`define FSP_BIT_CMP       14
`define FSP_BIT_ERS_PAUSE 15
`define FSP_BIT_DUMMY     16

// Reset values
`define FSP_STATUS_RESET  24'h000000
`define FSP_PINS_RESET    4'h5

// Dummy clock counts
`define FSP_DUMMY_DUAL_SHORT 4'h4
`define FSP_DUMMY_DUAL_LONG  4'h8
`define FSP_DUMMY_QUAD_SHORT 4'h6
`define FSP_DUMMY_QUAD_LONG  4'hA

// Timing
`define FSP_CLK_MHZ      50
`define FSP_T_PAGE_US    500
`define FSP_T_SECT_US    55000
`define FSP_T_BLK32_US   150000
`define FSP_T_BLK64_US   250000
`define FSP_T_CHIP_US    3000000
`define FSP_T_STATUS_US  2000

`endif

// file: fsp_pkg.sv
package fsp_pkg;

  typedef enum logic [1:0] {FSP_IDLE, FSP_BUSY, FSP_PAUSED} fsp_exec_t;

  typedef enum logic [1:0] {
    FSP_KIND_NONE,
    FSP_KIND_STATUS,
    FSP_KIND_PROG,
    FSP_KIND_ERASE
  } fsp_op_t;

endpackage

// file: fsp_sync.sv
`timescale 1ns/1ps
module fsp_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // fsp_sync

// file: fsp_guard.sv
`timescale 1ns/1ps
module fsp_guard (
  // Guard setting
  input  wire logic [4:0]  guard,
  input  wire logic        cmp,
  // Target address
  input  wire logic [19:0] addr,
  // Result
  output logic             hit,
  output logic             chipOk
);
  logic [8:0] size;
  logic [8:0] sect;
  logic [8:0] fromTop;
  logic       raw;

  always_comb begin
    sect    = {1'b0, addr[19:12]};
    fromTop = 9'h0FF - sect;
    size    = 9'h000;
    raw     = 1'b0;
    if (guard[2:0] == 3'h0) begin
      raw = 1'b0;
    end else if (guard[2:1] == 2'h3 || (!guard[4] && guard[2:0] == 3'h5)) begin
      raw = 1'b1;
    end else begin
      if (!guard[4]) begin
        case (guard[2:0])
          3'h1:    size = 9'h010;
          3'h2:    size = 9'h020;
          3'h3:    size = 9'h040;
          default: size = 9'h080;
        endcase
      end else begin
        case (guard[2:0])
          3'h1:    size = 9'h001;
          3'h2:    size = 9'h002;
          3'h3:    size = 9'h004;
          default: size = 9'h008;
        endcase
      end
      raw = guard[3] ? (sect < size) : (fromTop < size);
    end
    hit    = raw ^ cmp;
    chipOk = (guard[2:0] == 3'h0 && !cmp) || (guard[2:0] == 3'h7 && cmp);
  end
endmodule // fsp_guard

// file: fsp_status.sv
`timescale 1ns/1ps
`include "fsp_cfg.svh"
module fsp_status #(
  parameter int unsigned PAGE_CYC   = `FSP_T_PAGE_US * `FSP_CLK_MHZ,
  parameter int unsigned SECT_CYC   = `FSP_T_SECT_US * `FSP_CLK_MHZ,
  parameter int unsigned BLK32_CYC  = `FSP_T_BLK32_US * `FSP_CLK_MHZ,
  parameter int unsigned BLK64_CYC  = `FSP_T_BLK64_US * `FSP_CLK_MHZ,
  parameter int unsigned CHIP_CYC   = `FSP_T_CHIP_US * `FSP_CLK_MHZ,
  parameter int unsigned STATUS_CYC = `FSP_T_STATUS_US * `FSP_CLK_MHZ
) (
  // System
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Serial pins
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        si,
  input  wire logic        wpN,
  output logic             soOut,
  output logic             soOeN,
  // Configuration seen by the rest of the device
  output logic             quadMode,
  output logic [3:0]       dummyDual,
  output logic [3:0]       dummyQuad,
  output logic [2:0]       secureLock,
  output logic             busy,
  // Array operation launch
  output logic             arrayGo,
  output logic [7:0]       arrayKind,
  output logic [19:0]      arrayAddr
);
  logic              rstN;
  logic [3:0]        pinS;
  logic              sclkS, csS, siS, wpS;

  fsp_sync #(.W(1), .INIT(1'b0)) u_rst (
    .clk  (clk_sys),
    .rstN (nrst),
    .d    (1'b1),
    .q    (rstN)
  );

  fsp_sync #(.W(4), .INIT(`FSP_PINS_RESET)) u_pins (
    .clk  (clk_sys),
    .rstN (rstN),
    .d    ({sclk, csN, si, wpN}),
    .q    (pinS)
  );

  assign {sclkS, csS, siS, wpS} = pinS;

  // Frame receiver and status shifter
  logic              sclkPrev, csPrev;
  logic [2:0]        bitCnt, byteCnt, outIdx;
  logic [7:0]        shiftIn, cmd, b1, b2;
  logic [23:0]       addr;
  logic              next_sclkPrev, next_csPrev, next_soOut, next_soOeN;
  logic [2:0]        next_bitCnt, next_byteCnt, next_outIdx;
  logic [7:0]        next_shiftIn, next_cmd, next_b1, next_b2;
  logic [23:0]       next_addr;
  logic [7:0]        newByte, rdByte;
  logic              sclkRise, sclkFall, csRise, rdActive;
  logic [23:0]       statusWord;

  // Status register state
  fsp_pkg::fsp_exec_t state, next_state;
  fsp_pkg::fsp_op_t   opKind, next_opKind;
  logic [31:0]       timer, next_timer;
  logic              write_permit_latch, lockLo, lockHi, qe, cmp, progPause, ersPause, dummySel;
  logic [4:0]        guard;
  logic              next_wel, next_lockLo, next_lockHi, next_qe, next_cmp;
  logic              next_progPause, next_ersPause, next_dummySel, next_busy;
  logic [4:0]        next_guard;
  logic [2:0]        next_secureLock;
  logic              resetArmed, next_resetArmed, next_arrayGo, next_quadMode;
  logic [7:0]        next_arrayKind;
  logic [19:0]       next_arrayAddr;
  logic [3:0]        next_dummyDual, next_dummyQuad;
  logic              frameEnd, hwLocked, statusOk, statusGo, startCmd;
  logic              guardHit, chipOk;
  logic [23:0]       wrWord;
  logic [2:0]        wrMask;

  fsp_guard u_guard (
    .guard  (guard),
    .cmp    (cmp),
    .addr   (addr[19:0]),
    .hit    (guardHit),
    .chipOk (chipOk)
  );

  always_comb begin
    statusWord                                      = `FSP_STATUS_RESET;
    statusWord[`FSP_BIT_BUSY]                       = busy;
    statusWord[`FSP_BIT_PERMIT]                     = write_permit_latch;
    statusWord[`FSP_BIT_GUARD_HI:`FSP_BIT_GUARD_LO] = guard;
    statusWord[`FSP_BIT_LOCK_LOW]                   = lockLo;
    statusWord[`FSP_BIT_LOCK_HIGH]                  = lockHi;
    statusWord[`FSP_BIT_QUAD]                       = qe;
    statusWord[`FSP_BIT_PGM_PAUSE]                  = progPause;
    statusWord[`FSP_BIT_SEC_HI:`FSP_BIT_SEC_LO]     = secureLock;
    statusWord[`FSP_BIT_CMP]                        = cmp;
    statusWord[`FSP_BIT_ERS_PAUSE]                  = ersPause;
    statusWord[`FSP_BIT_DUMMY]                      = dummySel;
  end

  assign sclkRise = sclkS && !sclkPrev && !csS;
  assign sclkFall = !sclkS && sclkPrev && !csS;
  assign csRise   = csS && !csPrev;

  always_comb begin
    case (cmd)
      `FSP_OP_READ_LOW:  rdByte = statusWord[7:0];
      `FSP_OP_READ_MID:  rdByte = statusWord[15:8];
      `FSP_OP_READ_HIGH: rdByte = statusWord[23:16];
      default:           rdByte = 8'h00;
    endcase
    rdActive = (byteCnt != 3'h0) && (cmd == `FSP_OP_READ_LOW || cmd == `FSP_OP_READ_MID ||
                                     cmd == `FSP_OP_READ_HIGH);
  end

  always_comb begin
    newByte       = {shiftIn[6:0], siS};
    next_sclkPrev = sclkS;
    next_csPrev   = csS;
    next_bitCnt   = bitCnt;
    next_byteCnt  = byteCnt;
    next_shiftIn  = shiftIn;
    next_cmd      = cmd;
    next_addr     = addr;
    next_b1       = b1;
    next_b2       = b2;
    next_outIdx   = outIdx;
    next_soOut    = soOut;
    next_soOeN    = soOeN;
    if (csS) begin
      next_bitCnt  = 3'h0;
      next_byteCnt = 3'h0;
      next_outIdx  = 3'h0;
      next_cmd     = 8'h00;
      next_soOeN   = 1'b1;
    end else begin
      if (sclkRise) begin
        next_shiftIn = newByte;
        next_bitCnt  = bitCnt + 3'h1;
        if (bitCnt == 3'h7) begin
          case (byteCnt)
            3'h0:    next_cmd = newByte;
            3'h1:    next_b1 = newByte;
            3'h2:    next_b2 = newByte;
            default: ;
          endcase
          if (byteCnt >= 3'h1 && byteCnt <= 3'h3) begin
            next_addr = {addr[15:0], newByte};
          end
          if (byteCnt != 3'h7) begin
            next_byteCnt = byteCnt + 3'h1;
          end
        end
      end
      if (sclkFall && rdActive) begin
        next_soOut  = rdByte[3'h7 - outIdx];
        next_outIdx = outIdx + 3'h1;
        next_soOeN  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      sclkPrev <= 1'b0;
      csPrev   <= 1'b1;
      bitCnt   <= 3'h0;
      byteCnt  <= 3'h0;
      shiftIn  <= 8'h00;
      cmd      <= 8'h00;
      addr     <= 24'h000000;
      b1       <= 8'h00;
      b2       <= 8'h00;
      outIdx   <= 3'h0;
      soOut    <= 1'b0;
      soOeN    <= 1'b1;
    end else begin
      sclkPrev <= next_sclkPrev;
      csPrev   <= next_csPrev;
      bitCnt   <= next_bitCnt;
      byteCnt  <= next_byteCnt;
      shiftIn  <= next_shiftIn;
      cmd      <= next_cmd;
      addr     <= next_addr;
      b1       <= next_b1;
      b2       <= next_b2;
      outIdx   <= next_outIdx;
      soOut    <= next_soOut;
      soOeN    <= next_soOeN;
    end
  end

  // Commands other than status reads act only when chip select rises on a byte boundary
  assign frameEnd = csRise && (bitCnt == 3'h0) && (byteCnt != 3'h0);
  assign hwLocked = ({lockHi, lockLo} == 2'b01) && !qe && !wpS;
  assign statusOk = write_permit_latch && (state == fsp_pkg::FSP_IDLE) && !lockHi && !hwLocked;

  always_comb begin
    case (cmd)
      `FSP_OP_WRITE_LOW: begin
        wrWord = {8'h00, b2, b1};
        wrMask = {1'b0, byteCnt >= 3'h3, 1'b1};
      end
      `FSP_OP_WRITE_MID: begin
        wrWord = {8'h00, b1, 8'h00};
        wrMask = 3'b010;
      end
      default: begin
        wrWord = {b1, 16'h0000};
        wrMask = 3'b100;
      end
    endcase
  end

  always_comb begin
    next_state      = state;
    next_opKind     = opKind;
    next_timer      = timer;
    next_busy       = busy;
    next_wel        = write_permit_latch;
    next_lockLo     = lockLo;
    next_lockHi     = lockHi;
    next_guard      = guard;
    next_qe         = qe;
    next_cmp        = cmp;
    next_secureLock = secureLock;
    next_progPause  = progPause;
    next_ersPause   = ersPause;
    next_dummySel   = dummySel;
    next_resetArmed = resetArmed;
    next_arrayGo    = 1'b0;
    next_arrayKind  = arrayKind;
    next_arrayAddr  = arrayAddr;
    statusGo        = 1'b0;
    startCmd        = 1'b0;
    case (state)
      fsp_pkg::FSP_BUSY: begin
        if (timer <= 32'd1) begin
          next_state  = fsp_pkg::FSP_IDLE;
          next_opKind = fsp_pkg::FSP_KIND_NONE;
          next_timer  = 32'd0;
          next_busy   = 1'b0;
        end else begin
          next_timer = timer - 32'd1;
        end
      end
      default: ;
    endcase
    if (frameEnd) begin
      next_resetArmed = (cmd == `FSP_OP_RESET_ARM) && (byteCnt == 3'h1);
      case (cmd)
        `FSP_OP_RESET_GO: begin
          if (resetArmed) begin
            next_wel       = 1'b0;
            next_ersPause  = 1'b0;
            next_progPause = 1'b0;
            next_state     = fsp_pkg::FSP_IDLE;
            next_opKind    = fsp_pkg::FSP_KIND_NONE;
            next_timer     = 32'd0;
            next_busy      = 1'b0;
          end
        end
        `FSP_OP_WRITE_ENABLE: begin
          if (!busy) next_wel = 1'b1;
        end
        `FSP_OP_WRITE_DISABLE: begin
          if (!busy) next_wel = 1'b0;
        end
        `FSP_OP_PAUSE: begin
          if (state == fsp_pkg::FSP_BUSY && opKind != fsp_pkg::FSP_KIND_STATUS) begin
            if (opKind == fsp_pkg::FSP_KIND_ERASE) next_ersPause = 1'b1;
            else next_progPause = 1'b1;
            next_state = fsp_pkg::FSP_PAUSED;
            next_busy  = 1'b0;
          end
        end
        `FSP_OP_RESUME: begin
          next_ersPause  = 1'b0;
          next_progPause = 1'b0;
          if (state == fsp_pkg::FSP_PAUSED) begin
            next_state = fsp_pkg::FSP_BUSY;
            next_busy  = 1'b1;
          end
        end
        `FSP_OP_WRITE_LOW, `FSP_OP_WRITE_MID, `FSP_OP_WRITE_HIGH: begin
          if (state == fsp_pkg::FSP_IDLE && byteCnt >= 3'h2) begin
            next_wel = 1'b0;
            if (statusOk) begin
              statusGo = 1'b1;
              startCmd = 1'b1;
              if (wrMask[0]) begin
                next_lockLo = wrWord[`FSP_BIT_LOCK_LOW];
                next_guard  = wrWord[`FSP_BIT_GUARD_HI:`FSP_BIT_GUARD_LO];
              end
              if (wrMask[1]) begin
                next_lockHi     = wrWord[`FSP_BIT_LOCK_HIGH];
                next_qe         = wrWord[`FSP_BIT_QUAD];
                next_cmp        = wrWord[`FSP_BIT_CMP];
                next_secureLock = secureLock | wrWord[`FSP_BIT_SEC_HI:`FSP_BIT_SEC_LO];
              end
              if (wrMask[2]) next_dummySel = wrWord[`FSP_BIT_DUMMY];
              next_state  = fsp_pkg::FSP_BUSY;
              next_opKind = fsp_pkg::FSP_KIND_STATUS;
              next_timer  = STATUS_CYC;
              next_busy   = 1'b1;
            end
          end
        end
        `FSP_OP_PAGE_WRITE, `FSP_OP_SECTOR_CLEAR, `FSP_OP_BLOCK32_CLEAR,
        `FSP_OP_BLOCK64_CLEAR, `FSP_OP_CHIP_CLEAR_A, `FSP_OP_CHIP_CLEAR_B: begin
          if (state == fsp_pkg::FSP_IDLE && write_permit_latch &&
              ((cmd == `FSP_OP_PAGE_WRITE && byteCnt >= 3'h5) ||
               ((cmd == `FSP_OP_CHIP_CLEAR_A || cmd == `FSP_OP_CHIP_CLEAR_B) &&
                byteCnt == 3'h1) ||
               (cmd != `FSP_OP_PAGE_WRITE && cmd != `FSP_OP_CHIP_CLEAR_A &&
                cmd != `FSP_OP_CHIP_CLEAR_B && byteCnt == 3'h4))) begin
            next_wel = 1'b0;
            if ((byteCnt == 3'h1) ? chipOk : !guardHit) begin
              startCmd       = 1'b1;
              next_arrayGo   = 1'b1;
              next_arrayKind = cmd;
              next_arrayAddr = addr[19:0];
              next_state     = fsp_pkg::FSP_BUSY;
              next_busy      = 1'b1;
              case (cmd)
                `FSP_OP_PAGE_WRITE: begin
                  next_opKind = fsp_pkg::FSP_KIND_PROG;
                  next_timer  = PAGE_CYC;
                end
                `FSP_OP_SECTOR_CLEAR: begin
                  next_opKind = fsp_pkg::FSP_KIND_ERASE;
                  next_timer  = SECT_CYC;
                end
                `FSP_OP_BLOCK32_CLEAR: begin
                  next_opKind = fsp_pkg::FSP_KIND_ERASE;
                  next_timer  = BLK32_CYC;
                end
                `FSP_OP_BLOCK64_CLEAR: begin
                  next_opKind = fsp_pkg::FSP_KIND_ERASE;
                  next_timer  = BLK64_CYC;
                end
                default: begin
                  next_opKind = fsp_pkg::FSP_KIND_ERASE;
                  next_timer  = CHIP_CYC;
                end
              endcase
            end
          end
        end
        default: ;
      endcase
    end
    next_quadMode  = next_qe;
    next_dummyDual = next_dummySel ? `FSP_DUMMY_DUAL_LONG : `FSP_DUMMY_DUAL_SHORT;
    next_dummyQuad = next_dummySel ? `FSP_DUMMY_QUAD_LONG : `FSP_DUMMY_QUAD_SHORT;
  end

  // Registered copies of the configuration bits

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      // Power cycle: delivered state, lock bits back to 00
      state      <= fsp_pkg::FSP_IDLE;
      opKind     <= fsp_pkg::FSP_KIND_NONE;
      timer      <= 32'd0;
      busy       <= 1'b0;
      write_permit_latch        <= 1'b0;
      lockLo     <= 1'b0;
      lockHi     <= 1'b0;
      guard      <= 5'h00;
      qe         <= 1'b0;
      cmp        <= 1'b0;
      secureLock <= 3'h0;
      progPause  <= 1'b0;
      ersPause   <= 1'b0;
      dummySel   <= 1'b0;
      resetArmed <= 1'b0;
      arrayGo    <= 1'b0;
      arrayKind  <= 8'h00;
      arrayAddr  <= 20'h00000;
      quadMode   <= 1'b0;
      dummyDual  <= `FSP_DUMMY_DUAL_SHORT;
      dummyQuad  <= `FSP_DUMMY_QUAD_SHORT;
    end else begin
      state      <= next_state;
      opKind     <= next_opKind;
      timer      <= next_timer;
      busy       <= next_busy;
      write_permit_latch        <= next_wel;
      lockLo     <= next_lockLo;
      lockHi     <= next_lockHi;
      guard      <= next_guard;
      qe         <= next_qe;
      cmp        <= next_cmp;
      secureLock <= next_secureLock;
      progPause  <= next_progPause;
      ersPause   <= next_ersPause;
      dummySel   <= next_dummySel;
      resetArmed <= next_resetArmed;
      arrayGo    <= next_arrayGo;
      arrayKind  <= next_arrayKind;
      arrayAddr  <= next_arrayAddr;
      quadMode   <= next_quadMode;
      dummyDual  <= next_dummyDual;
      dummyQuad  <= next_dummyQuad;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstN);

  sequence s_frameCmd(logic [7:0] code);
    frameEnd && (cmd == code);
  endsequence

  AST_BUSY_STATE: assert property (busy == (state == fsp_pkg::FSP_BUSY))
    else $error("busy flag disagrees with operation state");
  AST_START_BUSY: assert property (startCmd |=> busy ##1 (busy || timer == 32'd0))
    else $error("accepted operation did not raise busy");
  AST_WEL_NEEDED: assert property (startCmd |-> write_permit_latch)
    else $error("operation started without permit latch");
  AST_WEL_CLEARS: assert property (startCmd |=> !write_permit_latch)
    else $error("permit latch not cleared by operation");
  AST_GUARD_CAUSE: assert property ($changed(guard) |-> $past(statusGo && !hwLocked))
    else $error("guard bits changed without allowed status write");
  AST_LOCK_REFUSE: assert property (frameEnd && (lockHi || hwLocked) |-> !statusGo)
    else $error("status write accepted while locked");
  AST_PROTECT: assert property ($rose(arrayGo) && (arrayKind != `FSP_OP_CHIP_CLEAR_A) &&
                                (arrayKind != `FSP_OP_CHIP_CLEAR_B) |-> $past(!guardHit))
    else $error("guarded address launched to array");
  AST_CHIP_GATE: assert property (arrayGo && (arrayKind == `FSP_OP_CHIP_CLEAR_A ||
                                  arrayKind == `FSP_OP_CHIP_CLEAR_B) |-> $past(chipOk))
    else $error("chip erase launched with guard set");
  AST_ERASE_PAUSE: assert property (s_frameCmd(`FSP_OP_PAUSE) ##0
                                    (state == fsp_pkg::FSP_BUSY &&
                                     opKind == fsp_pkg::FSP_KIND_ERASE)
                                    |=> ersPause && !busy && !progPause)
    else $error("erase pause flag not set");
  AST_RESUME: assert property (s_frameCmd(`FSP_OP_RESUME) |=> !ersPause && !progPause)
    else $error("resume did not clear paused flags");
  AST_OTP: assert property ((secureLock & $past(secureLock)) == $past(secureLock))
    else $error("secure-area lock bit returned to zero");
  AST_DUMMY: assert property (dummyQuad == (dummySel ? 4'hA : 4'h6))
    else $error("quad dummy count does not follow select bit");

endmodule // fsp_status

// file: fsp_host.sv
`timescale 1ns/1ps
module fsp_host (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      sclk,
  output logic      csN,
  output logic      si,
  input  wire logic so
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    si = 1'b0;
  end
  // Mode 0, MSB first; rd keeps the last eight bits seen on so
  task automatic frame(input logic [39:0] d, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    csN <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      si <= d[39-i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      rd = {rd[6:0], so};
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    csN <= 1'b1;
    // Released line shows a changed level, not the last bit
    si <= ~si;
    repeat (8) @(posedge clk);
  endtask
endmodule // fsp_host

// file: test_flash_status_protection.sv
`timescale 1ns/1ps
module test_flash_status_protection;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        wpN = 1'b1;
  logic        sclk, csN, si, soOut, soOeN, quadMode, busy, arrayGo;
  logic [2:0]  secureLock;
  logic [3:0]  dummyDual, dummyQuad;
  logic [7:0]  arrayKind, rd;
  logic [19:0] arrayAddr;
  int          num_errors = 0;
  int          checked = 0;
  int          goCnt = 0;
  int          oeCnt = 0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (arrayGo === 1'b1) goCnt <= goCnt + 1;
  always @(posedge clk_sys) if (soOeN === 1'b0) oeCnt <= oeCnt + 1;
  fsp_host host (.clk(clk_sys), .sclk(sclk), .csN(csN), .si(si), .so(soOut));
  fsp_status #(.PAGE_CYC(2000), .SECT_CYC(2000), .BLK64_CYC(20),
    .CHIP_CYC(20), .STATUS_CYC(20)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .csN(csN), .si(si), .wpN(wpN),
    .soOut(soOut), .soOeN(soOeN), .quadMode(quadMode), .dummyDual(dummyDual),
    .dummyQuad(dummyQuad), .secureLock(secureLock), .busy(busy), .arrayGo(arrayGo),
    .arrayKind(arrayKind), .arrayAddr(arrayAddr));
  task automatic chk(input string n, input logic [23:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame({op, 32'h0}, 8, rd);
  endtask
  task automatic wr(input logic [7:0] op, d);
    cmd(8'h06);
    host.frame({op, d, 24'h0}, 16, rd);
  endtask
  task automatic rr(input logic [7:0] op, exp);
    host.frame({op, 32'h0}, 16, rd);
    chk($sformatf("reg %h", op), {16'h0, rd}, {16'h0, exp});
  endtask
  task automatic idle;
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk_sys);
    chk("busy", {23'h0, busy}, 24'h0);
  endtask
  task automatic launch(input logic [39:0] d, input int nb, input int n);
    int c;
    c = goCnt;
    cmd(8'h06);
    host.frame(d, nb, rd);
    chk("launch", 24'(goCnt - c), 24'(n));
  endtask
  task automatic power_cycle;
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic t_reset;
    int c;
    c = oeCnt;
    rr(8'h05, 8'h00);
    chk("oe drive", {23'h0, oeCnt > c}, 24'h1);
    chk("oe idle", {23'h0, soOeN}, 24'h1);
    rr(8'h35, 8'h00);
    rr(8'h15, 8'h00);
    chk("dual", {20'h0, dummyDual}, 24'h4);
    chk("quad", {20'h0, dummyQuad}, 24'h6);
  endtask
  task automatic t_guard;
    host.frame({8'h01, 8'h04, 24'h0}, 16, rd);
    rr(8'h05, 8'h00);
    cmd(8'h06);
    rr(8'h05, 8'h02);
    host.frame({8'h01, 8'h04, 24'h0}, 16, rd);
    chk("busy", {23'h0, busy}, 24'h1);
    idle;
    rr(8'h05, 8'h04);
    launch({8'h20, 24'h0F0000, 8'h0}, 32, 0);
    rr(8'h05, 8'h04);
    launch({8'h20, 24'h010000, 8'h0}, 32, 1);
    chk("kind", {16'h0, arrayKind}, 24'h20);
    chk("addr", {4'h0, arrayAddr}, 24'h10000);
    cmd(8'h75);
    rr(8'h35, 8'h80);
    chk("busy", {23'h0, busy}, 24'h0);
    cmd(8'h7A);
    rr(8'h35, 8'h00);
    idle;
    launch({8'hC7, 32'h0}, 8, 0);
    wr(8'h01, 8'h00);
    idle;
    launch({8'hC7, 32'h0}, 8, 1);
    idle;
  endtask
  task automatic t_cfg;
    wr(8'h31, 8'h0A);
    idle;
    chk("qsel", {23'h0, quadMode}, 24'h1);
    chk("seclock", {21'h0, secureLock}, 24'h1);
    wr(8'h11, 8'hFF);
    idle;
    chk("dual", {20'h0, dummyDual}, 24'h8);
    chk("quad", {20'h0, dummyQuad}, 24'hA);
    rr(8'h15, 8'h01);
    wr(8'h31, 8'h00);
    idle;
    chk("qsel", {23'h0, quadMode}, 24'h0);
    chk("seclock", {21'h0, secureLock}, 24'h1);
    rr(8'h35, 8'h08);
  endtask
  task automatic t_prog;
    launch({8'h02, 24'h024000, 8'h5A}, 40, 1);
    chk("kind", {16'h0, arrayKind}, 24'h02);
    cmd(8'h75);
    rr(8'h35, 8'h0C);
    cmd(8'h66);
    cmd(8'h99);
    rr(8'h35, 8'h08);
    rr(8'h05, 8'h00);
    cmd(8'h06);
    cmd(8'h04);
    rr(8'h05, 8'h00);
  endtask
  task automatic t_power;
    power_cycle;
    rr(8'h35, 8'h00);
    chk("quad", {20'h0, dummyQuad}, 24'h6);
    cmd(8'h06);
    host.frame({8'h01, 8'h00, 8'h01, 16'h0}, 24, rd);
    idle;
    rr(8'h35, 8'h01);
    wr(8'h01, 8'h04);
    idle;
    rr(8'h05, 8'h00);
    power_cycle;
    wr(8'h01, 8'h04);
    idle;
    rr(8'h05, 8'h04);
  endtask
  task automatic t_lock;
    wr(8'h01, 8'h80);
    idle;
    @(posedge clk_sys) wpN <= 1'b0;
    wr(8'h01, 8'h84);
    idle;
    rr(8'h05, 8'h80);
    @(posedge clk_sys) wpN <= 1'b1;
    wr(8'h01, 8'h84);
    idle;
    rr(8'h05, 8'h84);
    wr(8'h31, 8'h01);
    idle;
    wr(8'h01, 8'h80);
    idle;
    rr(8'h05, 8'h84);
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    t_reset;
    t_guard;
    t_cfg;
    t_prog;
    t_lock;
    t_power;
    stop_test;
  end
  initial begin
    #1000000;
    num_errors++;
    stop_test;
  end
endmodule // test_flash_status_protection
